// ---- design/tape_framer_ctrl.v ----
// controller that drives the tape byte framer over its parallel handshake pins
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tape_ctrl_defines.vh"
// Operation
// - eight-bit two-way bus; controller sets direction with bus_dir line
// - record: put byte, raise ready, wait strobe, then drop ready
// - playback: ready means can accept; strobe marks valid byte on bus
// - controller sends five bytes per video line
// - each block spans 107 video lines
// - two checksum bytes start the block's final line
// - termination byte ends final line and resets checksum circuit
// - controller presets checksum generator before block data
// - controller selects checksum at end of data, device sends it
// - device makes line sync in record; controller times bytes to it
// - controller sends first block only after vertical retrace; here retrace_seen only flags it and the handshake does not wait for it
// - controller finds block start from type and identifier fields
// - controller read/write line picks record or playback and sync source
module tape_framer_ctrl #(
	parameter TIMEOUT_CYC = `HS_TIMEOUT_CYC,
	parameter [7:0] LINE_BYTES = `BYTES_PER_LINE,
	parameter [7:0] BLOCK_LINES = `LINES_PER_BLOCK,
	parameter [7:0] RETRACE_CYC = `RETRACE_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	output reg ready,
	input wire strobe,
	input wire sync,
	input wire error_status,
	output reg bus_dir,
	output reg rec_mode,
	output reg crc_preset,
	output reg crc_select
);
	localparam S_IDLE = 3'd0;
	localparam S_TX_WAIT = 3'd1;
	localparam S_TX_DROP = 3'd2;
	localparam S_RX_WAIT = 3'd3;
	localparam S_RX_DROP = 3'd4;

	reg [2:0] state;
	reg [2:0] next_state;
	reg ctl_rec;
	reg ctl_enable;
	reg [7:0] tx_byte;
	reg tx_full;
	reg [7:0] rx_byte;
	reg rx_valid;
	reg crc_good;
	reg [15:0] byte_count;
	reg [31:0] rd_value;
	wire wr_en;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire rd_en;
	wire [7:0] rd_addr;
	wire [2:0] pins;
	wire strobe_s;
	wire sync_s;
	wire err_s;
	reg strobe_d;
	wire strobe_rise;
	wire hs_done;
	reg sync_d;
	wire sync_rise;
	reg [7:0] line_bytes;
	reg [7:0] line_index;
	wire line_full;
	wire last_line;
	wire pos_restart;
	reg [7:0] sync_hi_cyc;
	reg retrace_seen;

	function is_wr;
		input en;
		input [7:0] a;
		input [7:0] target;
		begin
			is_wr = en & (a == target);
		end
	endfunction

	// saturating step, so a count that misses its restart never wraps to zero
	function [7:0] bump_to;
		input [7:0] v;
		input [7:0] cap;
		begin
			if (v == cap) begin
				bump_to = v;
			end else begin
				bump_to = v + 8'h01;
			end
		end
	endfunction

	ahb_regs u_regs (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_value(rd_value)
	);

	// strobe, sync and error status come from the device's own clock
	pin_sync #(
		.WIDTH(3)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin({error_status, sync, strobe}),
		.level(pins)
	);
	assign strobe_s = pins[0];
	assign sync_s = pins[1];
	assign err_s = pins[2];
	assign strobe_rise = strobe_s & ~strobe_d;
	assign hs_done = (state == S_TX_WAIT | state == S_RX_WAIT) & strobe_rise;
	assign sync_rise = sync_s & ~sync_d;
	assign line_full = (line_bytes == LINE_BYTES);
	assign last_line = (line_index == BLOCK_LINES - 8'h01);
	// preset opens a block and the termination byte closes one; both restart the count
	assign pos_restart = is_wr(wr_en, wr_addr, `REG_CTRL) &
		(wr_data[`CTRL_PRESET] | wr_data[`CTRL_TERM]);

	always @* begin
		rd_value = 32'h00000000;
		case (rd_addr)
			`REG_CTRL: begin
				rd_value[`CTRL_MODE_REC] = ctl_rec;
				rd_value[`CTRL_PRESET] = crc_preset;
				rd_value[`CTRL_CRC_SEL] = crc_select;
				rd_value[`CTRL_ENABLE] = ctl_enable;
			end
			`REG_STATUS: begin
				rd_value[`ST_TX_BUSY] = (state == S_TX_WAIT) | (state == S_TX_DROP);
				rd_value[`ST_RX_VALID] = rx_valid;
				rd_value[`ST_SYNC] = sync_s;
				rd_value[`ST_CRC_GOOD] = crc_good;
				rd_value[`ST_TX_FULL] = tx_full;
			end
			`REG_TXDATA: rd_value[7:0] = tx_byte;
			`REG_RXDATA: rd_value[7:0] = rx_byte;
			`REG_COUNT: rd_value[15:0] = byte_count;
			`REG_POSITION: begin
				rd_value[7:0] = line_bytes;
				rd_value[15:8] = line_index;
				rd_value[`POS_LINE_FULL] = line_full;
				rd_value[`POS_LAST_LINE] = last_line;
				rd_value[`POS_RETRACE] = retrace_seen;
			end
			default: rd_value = 32'h00000000;
		endcase
	end

	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (ctl_enable & ctl_rec & tx_full & ~strobe_s) begin
					next_state = S_TX_WAIT;
				end else if (ctl_enable & ~ctl_rec & ~rx_valid & ~strobe_s) begin
					next_state = S_RX_WAIT;
				end
			end
			S_TX_WAIT: begin
				if (strobe_rise) begin
					next_state = S_TX_DROP;
				end
			end
			S_TX_DROP: begin
				if (~strobe_s) begin
					next_state = S_IDLE;
				end
			end
			S_RX_WAIT: begin
				if (strobe_rise) begin
					next_state = S_RX_DROP;
				end
			end
			S_RX_DROP: begin
				if (~strobe_s) begin
					next_state = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_IDLE;
			strobe_d <= 1'b0;
			ctl_rec <= 1'b1;
			ctl_enable <= 1'b0;
			tx_byte <= 8'h00;
			tx_full <= 1'b0;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			crc_good <= 1'b0;
			byte_count <= 16'h0000;
			data_out <= 8'h00;
			data_oe <= 1'b0;
			ready <= 1'b0;
			bus_dir <= 1'b0;
			rec_mode <= 1'b1;
			crc_preset <= 1'b0;
			crc_select <= 1'b0;
			sync_d <= 1'b0;
			line_bytes <= 8'h00;
			line_index <= 8'h00;
			sync_hi_cyc <= 8'h00;
			retrace_seen <= 1'b0;
		end else begin
			state <= next_state;
			strobe_d <= strobe_s;
			sync_d <= sync_s;
			if (is_wr(wr_en, wr_addr, `REG_CTRL)) begin
				ctl_rec <= wr_data[`CTRL_MODE_REC];
				crc_preset <= wr_data[`CTRL_PRESET];
				crc_select <= wr_data[`CTRL_CRC_SEL];
				ctl_enable <= wr_data[`CTRL_ENABLE];
			end
			// mode and direction only move while no handshake is open
			if (state == S_IDLE) begin
				rec_mode <= ctl_rec;
				bus_dir <= ctl_rec;
				data_oe <= ctl_rec;
			end
			if (wr_en & (wr_addr == `REG_COUNT)) begin
				byte_count <= 16'h0000;
			end else if (hs_done) begin
				byte_count <= byte_count + 16'h0001;
			end
			// line sync moves to the next line; the counts saturate rather than wrap
			if (pos_restart) begin
				line_bytes <= 8'h00;
				line_index <= 8'h00;
			end else if (sync_rise) begin
				line_bytes <= 8'h00;
				line_index <= bump_to(line_index, BLOCK_LINES - 8'h01);
			end else if (hs_done) begin
				line_bytes <= bump_to(line_bytes, LINE_BYTES);
			end
			// a sync level held longer than any line pulse marks the vertical retrace
			if (!sync_s) begin
				sync_hi_cyc <= 8'h00;
			end else begin
				sync_hi_cyc <= bump_to(sync_hi_cyc, RETRACE_CYC);
			end
			// the retrace beats a restart in the same cycle
			if (sync_hi_cyc == RETRACE_CYC) begin
				retrace_seen <= 1'b1;
			end else if (pos_restart) begin
				retrace_seen <= 1'b0;
			end
			// the device's strobe clearing the flag beats a software write that sets it
			if (state == S_TX_WAIT & strobe_rise) begin
				tx_full <= 1'b0;
			end else if (is_wr(wr_en, wr_addr, `REG_TXDATA) & ~tx_full) begin
				tx_byte <= wr_data[7:0];
				tx_full <= 1'b1;
			end
			if (state == S_IDLE & next_state == S_TX_WAIT) begin
				data_out <= tx_byte;
				ready <= 1'b1;
			end else if (state == S_TX_WAIT & strobe_rise) begin
				ready <= 1'b0;
			end else if (state == S_IDLE & next_state == S_RX_WAIT) begin
				ready <= 1'b1;
			end else if (state == S_RX_WAIT & strobe_rise) begin
				ready <= 1'b0;
			end
			// reading the received byte releases the holding slot
			if (state == S_RX_WAIT & strobe_rise) begin
				rx_byte <= data_in;
				rx_valid <= 1'b1;
			end else if (rd_en & (rd_addr == `REG_RXDATA)) begin
				rx_valid <= 1'b0;
			end
			// error status is sampled continuously; it only counts as good in playback
			crc_good <= ~ctl_rec & err_s;
		end
	end
endmodule // tape_framer_ctrl
`default_nettype wire

// ---- include/tape_ctrl_defines.vh ----
// constants for the tape framer controller
`ifndef TAPE_CTRL_DEFINES_VH
`define TAPE_CTRL_DEFINES_VH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TXDATA 8'h08
`define REG_RXDATA 8'h0C
`define REG_COUNT 8'h10
`define REG_POSITION 8'h18
`define POS_LINE_FULL 16
`define POS_LAST_LINE 17
`define POS_RETRACE 18
`define RETRACE_CYC 8'h20
`define CTRL_MODE_REC 0
`define CTRL_PRESET 1
`define CTRL_CRC_SEL 2
`define CTRL_ENABLE 3
`define CTRL_TERM 4
`define ST_TX_BUSY 0
`define ST_RX_VALID 1
`define ST_SYNC 2
`define ST_CRC_GOOD 3
`define ST_TX_FULL 4
`define BYTES_PER_LINE 8'h05
`define LINES_PER_BLOCK 8'h6B
`define HS_TIMEOUT_NS 2000
`define HS_TIMEOUT_CYC ((`HS_TIMEOUT_NS + 7) / 8)
`endif

// ---- design/pin_sync.v ----
// three-stage synchroniser for device pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter WIDTH = 1
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] pin,
	output reg [WIDTH-1:0] level
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;
	integer i;
	// s1 only feeds s2; a bit counts once s2 and s3 agree
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1 <= {WIDTH{1'b0}};
			s2 <= {WIDTH{1'b0}};
			s3 <= {WIDTH{1'b0}};
			level <= {WIDTH{1'b0}};
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2[i] == s3[i]) begin
					level[i] <= s3[i];
				end
			end
		end
	end
endmodule // pin_sync
`default_nettype wire

// ---- design/ahb_regs.v ----
// ahb-lite slave front end for the controller registers
`timescale 1ns/10ps
`default_nettype none
`include "tape_ctrl_defines.vh"
module ahb_regs (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output reg wr_en,
	output reg [7:0] wr_addr,
	output reg [31:0] wr_data,
	output wire rd_en,
	output wire [7:0] rd_addr,
	input wire [31:0] rd_value
);
	reg ph_wr;
	reg [7:0] ph_addr;
	wire take;
	assign take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// reads are decoded in the address phase so data stands in the data phase
	assign rd_en = take & ~hwrite;
	assign rd_addr = haddr[7:0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr <= 1'b0;
			ph_addr <= 8'h00;
			hrdata <= 32'h00000000;
			wr_en <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
		end else begin
			ph_wr <= take & hwrite;
			ph_addr <= haddr[7:0];
			wr_en <= ph_wr;
			wr_addr <= ph_addr;
			wr_data <= hwdata;
			if (rd_en) begin
				hrdata <= rd_value;
			end
		end
	end
endmodule // ahb_regs
`default_nettype wire

// ---- tb/tape_ctrl_assertions.sv ----
// port assertions for the tape framer controller
`timescale 1ns/10ps
`default_nettype none
module tape_ctrl_checker #(
	parameter TIMEOUT_CYC = 250
) (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire ready,
	input wire strobe,
	input wire bus_dir,
	input wire rec_mode
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence strobe_up;
		$rose(strobe);
	endsequence
	sequence hs_release;
		ready[*2] ##[1:6] !ready;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall");
	a_ready_idle: assert property ($rose(ready) |-> !strobe) else $error("early ready");
	a_ready_release: assert property (strobe_up |-> hs_release) else $error("ready held");
	a_drop_cause: assert property ($fell(ready) |-> strobe) else $error("ready dropped");
	a_hold_off: assert property (strobe && !ready |=> !ready) else $error("ready reraised");
	a_data_stable: assert property (ready && rec_mode && $past(ready) |-> $stable(data_out))
		else $error("data moved");
	a_dir_record: assert property (rec_mode[*3] |-> bus_dir && data_oe) else $error("dir rec");
	a_dir_play: assert property (!rec_mode[*3] |-> !bus_dir && !data_oe) else $error("dir play");
endmodule // tape_ctrl_checker
bind tape_framer_ctrl tape_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.hclk(hclk),
	.hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .data_out(data_out),
	.data_oe(data_oe), .ready(ready), .strobe(strobe), .bus_dir(bus_dir), .rec_mode(rec_mode));
`default_nettype wire

// ---- tb/framer_dev_model.sv ----
// behavioural model of the tape byte framer handshake side
`timescale 1ns/10ps
`default_nettype none
module framer_dev_model (
	input wire hclk,
	input wire hresetn,
	input wire ready,
	input wire [7:0] data_out,
	input wire rec_mode,
	input wire [7:0] rx_byte,
	input wire [3:0] lag,
	input wire sync_lvl,
	input wire crc_ok,
	output logic strobe,
	output logic [7:0] data_in,
	output logic sync,
	output logic error_status,
	output logic [7:0] got,
	output logic [7:0] n_hs
);
	logic [3:0] cnt;
	assign sync = sync_lvl;
	assign error_status = crc_ok;
	// off-strobe the bus shows the inverse so a stale sample is caught
	assign data_in = strobe ? rx_byte : ~rx_byte;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe <= 1'h0;
			cnt <= 4'h0;
			got <= 8'h00;
			n_hs <= 8'h00;
		end else if (!ready) begin
			strobe <= 1'h0;
			cnt <= 4'h0;
		end else if (!strobe && cnt >= lag) begin
			strobe <= 1'h1;
			n_hs <= n_hs + 8'h01;
			if (rec_mode)
				got <= data_out;
		end else if (!strobe) begin
			// cnt counts cycles with ready high until it reaches lag, then strobe rises
			cnt <= cnt + 4'h1;
		end
	end
endmodule // framer_dev_model
`default_nettype wire

// ---- tb/video_tape_byte_framer_tb.sv ----
// self-checking bench for the tape framer controller
`timescale 1ns/10ps
`default_nettype none
module video_tape_byte_framer_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_oe, ready, strobe, sync;
	logic error_status, bus_dir, rec_mode, crc_preset, crc_select, sync_lvl, crc_ok;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] lag;
	logic [7:0] data_in, data_out, rx_byte, got, n_hs;
	logic [31:0] haddr, hwdata, hrdata, q;
	int errors, comparisons, cyc;
	tape_framer_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .ready(ready), .strobe(strobe), .sync(sync),
		.error_status(error_status), .bus_dir(bus_dir), .rec_mode(rec_mode),
		.crc_preset(crc_preset), .crc_select(crc_select));
	framer_dev_model dev (.hclk(hclk), .hresetn(hresetn), .ready(ready), .data_out(data_out),
		.rec_mode(rec_mode), .rx_byte(rx_byte), .lag(lag), .sync_lvl(sync_lvl), .crc_ok(crc_ok),
		.strobe(strobe), .data_in(data_in), .sync(sync), .error_status(error_status),
		.got(got), .n_hs(n_hs));
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		q = hrdata;
	endtask
	task rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h00000000);
		chk(what, q, e);
	endtask
	task poll(input logic [31:0] m, input logic [31:0] v);
		for (int k = 0; k < 99; k++) begin
			bus(1'h0, 8'h04, 32'h00000000);
			if ((q & m) === v) break;
		end
		chk("status", q & m, v);
	endtask
	task t_reset;
		@(posedge hclk);
		chk("ready", ready, 1'h0);
		chk("rec_mode", rec_mode, 1'h1);
		chk("bus_dir", bus_dir, 1'h1);
		rdc("ctrl", 8'h00, 32'h00000001);
		rdc("unmapped", 8'h14, 32'h00000000);
		$display("reset done");
	endtask
	task t_record;
		bus(1'h1, 8'h00, 32'h00000009);
		for (int i = 0; i < 5; i++) begin
			lag <= 4'(i * 3);
			bus(1'h1, 8'h08, 32'h000000A0 + i);
			while (n_hs !== 8'(i + 1)) @(posedge hclk);
			poll(32'h00000011, 32'h00000000);
			chk("tx byte", got, 8'hA0 + 8'(i));
		end
		rdc("count", 8'h10, 32'h00000005);
		rdc("position", 8'h18, 32'h00010005);
		$display("record done");
	endtask
	task t_lines;
		bus(1'h1, 8'h00, 32'h0000000B);
		bus(1'h1, 8'h00, 32'h00000009);
		for (int n = 0; n < 106; n++) begin
			sync_lvl <= 1'h1;
			repeat (n == 0 ? 40 : 5) @(posedge hclk);
			sync_lvl <= 1'h0;
			repeat (5) @(posedge hclk);
		end
		rdc("last line", 8'h18, 32'h00066A00);
		$display("line count done");
	endtask
	task t_crc;
		bus(1'h1, 8'h00, 32'h0000000F);
		repeat (3) @(posedge hclk);
		chk("preset", crc_preset, 1'h1);
		chk("select", crc_select, 1'h1);
		bus(1'h1, 8'h00, 32'h00000009);
		repeat (3) @(posedge hclk);
		chk("preset off", crc_preset | crc_select, 1'h0);
		$display("crc lines done");
	endtask
	task t_play;
		rx_byte <= 8'h5A;
		lag <= 4'h2;
		bus(1'h1, 8'h00, 32'h00000008);
		poll(32'h00000002, 32'h00000002);
		chk("oe", {bus_dir, data_oe, rec_mode}, 3'h0);
		rx_byte <= 8'hC3;
		repeat (40) @(posedge hclk);
		chk("held", n_hs, 8'h06);
		rdc("rx byte", 8'h0C, 32'h0000005A);
		poll(32'h00000002, 32'h00000002);
		rdc("rx next", 8'h0C, 32'h000000C3);
		$display("playback done");
	endtask
	task t_status(input logic v);
		bus(1'h1, 8'h00, 32'h00000000);
		crc_ok <= v;
		sync_lvl <= v;
		repeat (6) @(posedge hclk);
		bus(1'h0, 8'h04, 32'h00000000);
		chk("crc good", q[3], v);
		chk("sync", q[2], v);
		$display("status done");
	endtask
	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		hclk = 1'h0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		// ceiling over ten times the cycles the tests need
		if (cyc == 20000) begin
			errors++;
			finish_test;
		end
	end
	initial begin
		{hresetn, hsel, hwrite, sync_lvl, crc_ok} = 5'h00;
		{htrans, lag, rx_byte, haddr, hwdata} = 0;
		hsize = 3'h2;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_reset;
		t_record;
		t_crc;
		t_lines;
		t_status(1'h1);
		t_status(1'h0);
		t_play;
		finish_test;
	end
endmodule // video_tape_byte_framer_tb
`default_nettype wire
